// File: rtl/skip_branch_unit.sv
// Conditional skip and relative branch control unit of the core
`timescale 1ns/1ps
module skip_branch_unit
    import skip_branch_pkg::*;
#(
    parameter int PC_W = skip_branch_pkg::PC_WIDTH,
    parameter int K_W  = skip_branch_pkg::OFS_WIDTH
) (
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    // Operation request from the decoder
    input  wire logic                      req_valid,
    output logic                           req_ready,
    input  wire skip_branch_pkg::op_e      req_op,
    input  wire logic [2:0]                req_bit,
    input  wire logic [K_W-1:0]            req_offset,
    input  wire logic [PC_W-1:0]           req_pc,
    input  wire logic                      req_next_two_word,
    // Operand sources
    input  wire logic [7:0]                reg_value,
    input  wire logic [7:0]                io_value,
    input  wire logic [7:0]                status_flags_register,
    // Outcome to the program counter
    output logic                           done,
    output logic [PC_W-1:0]                pc_next,
    output logic                           taken,
    output logic [1:0]                     cycles_used
);
    import skip_branch_pkg::*;

    // ------------------------------------------------------------
    // Condition evaluation
    // ------------------------------------------------------------
    typedef enum logic {st_idle, st_stall} state_e;

    state_e          state_r;
    logic [1:0]      cnt_r;
    logic            done_r;
    logic            taken_r;
    logic [PC_W-1:0] pc_r;
    logic [1:0]      cyc_r;
    logic            accept;

    cond_if #(.PC_W(PC_W), .K_W(K_W)) cif ();

    assign cif.op            = req_op;
    assign cif.bit_sel       = req_bit;
    assign cif.reg_value     = reg_value;
    assign cif.io_value      = io_value;
    assign cif.flags         = status_flags_register;
    assign cif.offset        = req_offset;
    assign cif.pc            = req_pc;
    assign cif.next_two_word = req_next_two_word;

    cond_eval #(.PC_W(PC_W), .K_W(K_W)) u_eval (
        .c (cif.eval)
    );

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    // A new operation is only taken while no stall is running
    assign req_ready = (state_r == st_idle);
    assign accept    = req_valid && req_ready;

    // Stall state: extra cycles of a skip or a taken branch
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= st_idle;
            cnt_r   <= CNT_RESET;
        end else begin
            case (state_r)
                st_idle: begin
                    if (accept && (cif.cycles != CYC_FALL)) begin
                        state_r <= st_stall;
                        cnt_r   <= cif.cycles - 2'h2;
                    end
                end
                st_stall: begin
                    if (cnt_r == 2'h0) begin
                        state_r <= st_idle;
                    end else begin
                        cnt_r <= cnt_r - 2'h1;
                    end
                end
                default: begin
                    state_r <= st_idle;
                end
            endcase
        end
    end

    // Outcome is latched at acceptance so the caller may move on
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pc_r    <= '0;
            taken_r <= 1'b0;
            cyc_r   <= CYC_RESET;
        end else if (accept) begin
            pc_r    <= cif.target;
            taken_r <= cif.cond_met;
            cyc_r   <= cif.cycles;
        end
    end

    // Completion pulse on the last cycle of the operation
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (accept && (cif.cycles == CYC_FALL)) ||
                      ((state_r == st_stall) && (cnt_r == 2'h0));
        end
    end

    assign done        = done_r;
    assign pc_next     = pc_r;
    assign taken       = taken_r;
    assign cycles_used = cyc_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    function automatic logic [PC_W-1:0] sext(input logic [K_W-1:0] k);
        sext = {{(PC_W-K_W){k[K_W-1]}}, k};
    endfunction

    property p_reg_set_skip;
        accept && req_op == skip_if_reg_bit_set && reg_value[req_bit] && !req_next_two_word
        |=> !done ##1 done && pc_next == $past(req_pc, 2) + PC_W'(SKIP_ONE_WORD);
    endproperty
    a_reg_set_skip: assert property (p_reg_set_skip) else $error("register-bit skip wrong");

    property p_io_clear_skip;
        accept && req_op == skip_if_io_bit_clear && !io_value[req_bit] && req_next_two_word
        |=> !done [*2] ##1 done && pc_next == $past(req_pc, 3) + PC_W'(SKIP_TWO_WORD);
    endproperty
    a_io_clear_skip: assert property (p_io_clear_skip) else $error("io-clear skip wrong");

    property p_io_set_fall;
        accept && req_op == skip_if_io_bit_set && !io_value[req_bit]
        |=> done && !taken && pc_next == $past(req_pc) + PC_W'(STEP_SEQ);
    endproperty
    a_io_set_fall: assert property (p_io_set_fall) else $error("io-set fall-through wrong");

    property p_flag_set_branch;
        accept && req_op == branch_on_flag_set && status_flags_register[req_bit]
        |=> !done ##1 done && taken &&
            pc_next == $past(req_pc, 2) + sext($past(req_offset, 2)) + PC_W'(STEP_SEQ);
    endproperty
    a_flag_set_branch: assert property (p_flag_set_branch) else $error("flag-set branch wrong");

    property p_not_equal;
        accept && req_op == branch_on_not_equal && status_flags_register[ZERO_FLAG_POS]
        |=> done && !taken && cycles_used == CYC_FALL;
    endproperty
    a_not_equal: assert property (p_not_equal) else $error("not-equal fall-through wrong");

    property p_cycle_cost;
        done |-> (taken == (cycles_used != CYC_FALL)) && cycles_used != CYC_RESET;
    endproperty
    a_cycle_cost: assert property (p_cycle_cost) else $error("cycle cost inconsistent");

    property p_stall_blocks;
        accept && cif.cycles == CYC_SKIP_TWO |=> !req_ready [*2] ##1 req_ready;
    endproperty
    a_stall_blocks: assert property (p_stall_blocks) else $error("stall length wrong");

    property p_reg_set_fall;
        accept && req_op == skip_if_reg_bit_set && !reg_value[req_bit]
        |=> done && !taken && cycles_used == CYC_FALL;
    endproperty
    a_reg_set_fall: assert property (p_reg_set_fall) else $error("register-bit fall-through wrong");

    property p_io_clear_fall;
        accept && req_op == skip_if_io_bit_clear && io_value[req_bit]
        |=> done && !taken && pc_next == $past(req_pc) + PC_W'(STEP_SEQ);
    endproperty
    a_io_clear_fall: assert property (p_io_clear_fall) else $error("io-clear fall-through wrong");

    property p_io_set_skip;
        accept && req_op == skip_if_io_bit_set && io_value[req_bit] && !req_next_two_word
        |=> !done ##1 done && taken && pc_next == $past(req_pc, 2) + PC_W'(SKIP_ONE_WORD);
    endproperty
    a_io_set_skip: assert property (p_io_set_skip) else $error("io-set skip wrong");

    property p_flag_set_fall;
        accept && req_op == branch_on_flag_set && !status_flags_register[req_bit]
        |=> done && !taken && pc_next == $past(req_pc) + PC_W'(STEP_SEQ);
    endproperty
    a_flag_set_fall: assert property (p_flag_set_fall) else $error("flag-set fall-through wrong");

    property p_equal_branch;
        accept && req_op == branch_on_equal && status_flags_register[ZERO_FLAG_POS]
        |=> !done ##1 done && taken && cycles_used == CYC_BRANCH;
    endproperty
    a_equal_branch: assert property (p_equal_branch) else $error("equal branch wrong");

    property p_flag_clear_branch;
        accept && req_op == branch_on_flag_clear && !status_flags_register[req_bit]
        |=> !done ##1 done && taken && pc_next == $past(req_pc, 2) + sext($past(req_offset, 2)) + PC_W'(STEP_SEQ);
    endproperty
    a_flag_clear_branch: assert property (p_flag_clear_branch) else $error("flag-clear branch wrong");

    property p_reg_clear_two;
        accept && req_op == skip_if_reg_bit_clear && !reg_value[req_bit] && req_next_two_word
        |=> !done [*2] ##1 done && taken && cycles_used == CYC_SKIP_TWO;
    endproperty
    a_reg_clear_two: assert property (p_reg_clear_two) else $error("two-word skip cost wrong");

    // A lone completion never repeats unless a new operation was taken
    property p_done_single;
        done && !accept
        |=> !done;
    endproperty
    a_done_single: assert property (p_done_single) else $error("done longer than one cycle");

    // The caller may read the outcome late, so it must hold until the next accept
    property p_outcome_holds;
        !accept
        |=> $stable(pc_next) && $stable(taken) && $stable(cycles_used);
    endproperty
    a_outcome_holds: assert property (p_outcome_holds) else $error("outcome changed without accept");

    c_two_word_skip: cover property (accept && cif.cycles == CYC_SKIP_TWO);
    c_branch_taken:  cover property (accept && req_op == branch_on_equal && cif.cond_met);
    c_back_to_back:  cover property (done && accept);
    c_refused:       cover property (req_valid && !req_ready);

endmodule

// File: rtl/skip_branch_pkg.sv
// Constants and types shared by the conditional skip and branch unit
// How it works
// - Register-bit-set skip advances program counter by 2 or 3, flags untouched.
// - I/O-bit-clear skip advances by 2 or 3, else sequential, no flag change.
// - I/O-bit-set skip advances by 2 or 3 in 2 or 3 cycles.
// - Flag-set branch, equal variant included, loads PC plus k plus 1.
// - Flag-clear branch, not-equal included, loads PC plus k plus 1; fall-through one cycle.
package skip_branch_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PC_WIDTH  = 16;
    localparam int OFS_WIDTH = 7;

    // ------------------------------------------------------------
    // Operations handled by the unit
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        skip_if_reg_bit_clear,
        skip_if_reg_bit_set,
        skip_if_io_bit_clear,
        skip_if_io_bit_set,
        branch_on_flag_set,
        branch_on_flag_clear,
        branch_on_equal,
        branch_on_not_equal
    } op_e;

    // ------------------------------------------------------------
    // Distances, cycle counts, flag positions, reset values
    // ------------------------------------------------------------
    localparam logic [1:0] STEP_SEQ       = 2'h1;
    localparam logic [1:0] SKIP_ONE_WORD  = 2'h2;
    localparam logic [1:0] SKIP_TWO_WORD  = 2'h3;
    localparam logic [1:0] CYC_FALL       = 2'h1;
    localparam logic [1:0] CYC_BRANCH     = 2'h2;
    localparam logic [1:0] CYC_SKIP_ONE   = 2'h2;
    localparam logic [1:0] CYC_SKIP_TWO   = 2'h3;
    localparam logic [2:0] ZERO_FLAG_POS  = 3'h1;
    localparam logic [1:0] CNT_RESET      = 2'h0;
    localparam logic [1:0] CYC_RESET      = 2'h0;

endpackage

// File: rtl/cond_if.sv
// Carrier between the controller and the condition evaluator
`timescale 1ns/1ps
interface cond_if
    import skip_branch_pkg::*;
#(
    parameter int PC_W = PC_WIDTH,
    parameter int K_W  = OFS_WIDTH
);
    // Operands of the operation on offer
    op_e              op;
    logic [2:0]       bit_sel;
    logic [7:0]       reg_value;
    logic [7:0]       io_value;
    logic [7:0]       flags;
    logic [K_W-1:0]   offset;
    logic [PC_W-1:0]  pc;
    logic             next_two_word;
    // Verdict
    logic             cond_met;
    logic [PC_W-1:0]  target;
    logic [1:0]       cycles;

    modport eval (
        input  op, bit_sel, reg_value, io_value, flags, offset, pc, next_two_word,
        output cond_met, target, cycles
    );
    modport ctrl (
        output op, bit_sel, reg_value, io_value, flags, offset, pc, next_two_word,
        input  cond_met, target, cycles
    );
endinterface

// File: rtl/cond_eval.sv
// Decides skip or branch outcome, new program counter and cycle cost
`timescale 1ns/1ps
module cond_eval
    import skip_branch_pkg::*;
#(
    parameter int PC_W = PC_WIDTH,
    parameter int K_W  = OFS_WIDTH
) (
    // Operands in, verdict out
    cond_if.eval c
);
    import skip_branch_pkg::*;

    logic            tested_bit;
    logic            is_skip;
    logic [PC_W-1:0] k_ext;

    // Sign-extend the relative offset so backward branches wrap correctly
    assign k_ext = {{(PC_W-K_W){c.offset[K_W-1]}}, c.offset};

    // Pick the bit under test and the sense of the test
    always_comb begin
        tested_bit = 1'b0;
        is_skip    = 1'b0;
        c.cond_met = 1'b0;
        case (c.op)
            skip_if_reg_bit_clear: begin
                is_skip    = 1'b1;
                c.cond_met = ~c.reg_value[c.bit_sel];
            end
            skip_if_reg_bit_set: begin
                is_skip    = 1'b1;
                c.cond_met = c.reg_value[c.bit_sel];
            end
            skip_if_io_bit_clear: begin
                is_skip    = 1'b1;
                c.cond_met = ~c.io_value[c.bit_sel];
            end
            skip_if_io_bit_set: begin
                is_skip    = 1'b1;
                c.cond_met = c.io_value[c.bit_sel];
            end
            branch_on_flag_set: begin
                c.cond_met = c.flags[c.bit_sel];
            end
            branch_on_flag_clear: begin
                c.cond_met = ~c.flags[c.bit_sel];
            end
            branch_on_equal: begin
                tested_bit = c.flags[ZERO_FLAG_POS];
                c.cond_met = tested_bit;
            end
            branch_on_not_equal: begin
                tested_bit = c.flags[ZERO_FLAG_POS];
                c.cond_met = ~tested_bit;
            end
            default: begin
                c.cond_met = 1'b0;
            end
        endcase
    end

    // New program counter and cost; the flags are only read, never written
    always_comb begin
        c.target = c.pc + PC_W'(STEP_SEQ);
        c.cycles = CYC_FALL;
        if (c.cond_met && is_skip) begin
            if (c.next_two_word) begin
                c.target = c.pc + PC_W'(SKIP_TWO_WORD);
                c.cycles = CYC_SKIP_TWO;
            end else begin
                c.target = c.pc + PC_W'(SKIP_ONE_WORD);
                c.cycles = CYC_SKIP_ONE;
            end
        end else if (c.cond_met) begin
            c.target = c.pc + k_ext + PC_W'(STEP_SEQ);
            c.cycles = CYC_BRANCH;
        end
    end

endmodule

// File: sim/test_conditional_skip_branch_unit.sv
// Self-checking random and corner-case bench for the skip and branch unit
`timescale 1ns/1ps
module test_conditional_skip_branch_unit;
    import skip_branch_pkg::*;

    // ------------------------------------------------------------
    // Port signals and bench counters
    // ------------------------------------------------------------
    logic                 sys_clk;
    logic                 rst;
    logic                 req_valid;
    logic                 req_ready;
    op_e                  req_op;
    logic [2:0]           req_bit;
    logic [OFS_WIDTH-1:0] req_offset;
    logic [PC_WIDTH-1:0]  req_pc;
    logic                 req_next_two_word;
    logic [7:0]           reg_value;
    logic [7:0]           io_value;
    logic [7:0]           status_flags_register;
    logic                 done;
    logic [PC_WIDTH-1:0]  pc_next;
    logic                 taken;
    logic [1:0]           cycles_used;
    int                   fails;
    int                   check_count;
    integer               seed;

    // 25 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    skip_branch_unit #(.PC_W(PC_WIDTH), .K_W(OFS_WIDTH)) dut (
        .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req_op(req_op), .req_bit(req_bit), .req_offset(req_offset), .req_pc(req_pc),
        .req_next_two_word(req_next_two_word), .reg_value(reg_value), .io_value(io_value),
        .status_flags_register(status_flags_register), .done(done), .pc_next(pc_next),
        .taken(taken), .cycles_used(cycles_used)
    );

    // ------------------------------------------------------------
    // Comparison, closing report and reference model
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Expected new PC, taken flag and cycle cost, worked out from the operands
    function automatic void model(input op_e op, input logic [2:0] b, input logic [OFS_WIDTH-1:0] k,
        input logic [PC_WIDTH-1:0] pc, input logic two, input logic [7:0] rv, input logic [7:0] iv,
        input logic [7:0] fl, output logic [PC_WIDTH-1:0] p, output logic t, output logic [1:0] c);
        logic hit;
        logic is_skip;
        is_skip = (op inside {skip_if_reg_bit_clear, skip_if_reg_bit_set,
                              skip_if_io_bit_clear, skip_if_io_bit_set});
        case (op)
            skip_if_reg_bit_clear: hit = ~rv[b];
            skip_if_reg_bit_set:   hit = rv[b];
            skip_if_io_bit_clear:  hit = ~iv[b];
            skip_if_io_bit_set:    hit = iv[b];
            branch_on_flag_set:    hit = fl[b];
            branch_on_flag_clear:  hit = ~fl[b];
            branch_on_equal:       hit = fl[ZERO_FLAG_POS];
            default:               hit = ~fl[ZERO_FLAG_POS];
        endcase
        t = hit;
        if (!hit) begin
            p = pc + 16'h0001;
            c = 2'h1;
        end else if (is_skip) begin
            p = pc + (two ? 16'h0003 : 16'h0002);
            c = two ? 2'h3 : 2'h2;
        end else begin
            p = pc + {{(PC_WIDTH-OFS_WIDTH){k[OFS_WIDTH-1]}}, k} + 16'h0001;
            c = 2'h2;
        end
    endfunction

    // ------------------------------------------------------------
    // One operation: offer, hold while busy, judge at done
    // ------------------------------------------------------------
    task automatic run_op(input op_e op, input logic [2:0] b, input logic [OFS_WIDTH-1:0] k,
        input logic [PC_WIDTH-1:0] pc, input logic two, input logic [7:0] v0, input logic [7:0] v1,
        input logic [7:0] v2);
        logic [PC_WIDTH-1:0] ep;
        logic                et;
        logic [1:0]          ec;
        int                  n;
        model(op, b, k, pc, two, v0, v1, v2, ep, et, ec);
        req_valid = 1'b1;
        req_op = op;
        req_bit = b;
        req_offset = k;
        req_pc = pc;
        req_next_two_word = two;
        reg_value = v0;
        io_value = v1;
        status_flags_register = v2;
        n = 0;
        while (req_ready !== 1'b1) begin
            @(negedge sys_clk);
            n++;
            if (n > 8) begin
                fails++;
                end_sim();
            end
        end
        @(negedge sys_clk);
        n = 1;
        // Valid stays high with scrambled operands, so a late sample shows up as a wrong result
        while (done !== 1'b1) begin
            check(req_ready, 1'b0);
            req_op = op_e'(~op);
            req_bit = ~b;
            req_offset = ~k;
            req_pc = ~pc;
            req_next_two_word = ~two;
            reg_value = ~v0;
            io_value = ~v1;
            status_flags_register = ~v2;
            @(negedge sys_clk);
            n++;
            if (n > 4) begin
                fails++;
                end_sim();
            end
        end
        check(n, ec);
        check(cycles_used, ec);
        check(pc_next, ep);
        check(taken, et);
        check(req_ready, 1'b1);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r1;
        logic [31:0] r2;
        logic [7:0]  v;
        seed = 32'h18c916c6;
        fails = 0;
        check_count = 0;
        rst = 1'b1;
        req_valid = 1'b0;
        req_op = skip_if_reg_bit_clear;
        req_bit = 3'h0;
        req_offset = 7'h00;
        req_pc = 16'h0000;
        req_next_two_word = 1'b0;
        reg_value = 8'h00;
        io_value = 8'h00;
        status_flags_register = 8'h00;
        repeat (3) @(negedge sys_clk);
        check(req_ready, 1'b1);
        check(done, 1'b0);
        check(pc_next, 16'h0000);
        rst = 1'b0;
        // Every operation, both outcomes, one and two words, extreme offsets, PC wrap
        for (int i = 0; i < 32; i++) begin
            v = i[0] ? 8'hFF : 8'h00;
            run_op(op_e'(i[4:2]), 3'(i), i[1] ? 7'h3F : 7'h40, 16'hFFFE, i[1], v, v, v);
        end
        // Reset in mid-run clears the outcome
        rst = 1'b1;
        req_valid = 1'b0;
        @(negedge sys_clk);
        check(taken, 1'b0);
        check(cycles_used, 2'h0);
        check(done, 1'b0);
        check(pc_next, 16'h0000);
        check(req_ready, 1'b1);
        rst = 1'b0;
        // Random traffic, back to back with occasional idle gaps
        for (int i = 0; i < 400; i++) begin
            r1 = $random(seed);
            r2 = $random(seed);
            if (r2[31:30] == 2'h0) begin
                req_valid = 1'b0;
                @(negedge sys_clk);
            end
            run_op(op_e'(r1[2:0]), r1[5:3], r1[12:6], r1[31:16], r1[13], r2[7:0], r2[15:8], r2[23:16]);
        end
        req_valid = 1'b0;
        repeat (2) @(negedge sys_clk);
        end_sim();
    end
endmodule
